// ### src/asd_pkg.sv
// package for the adc scan, dac load and power-down control block
// assumes a serial front end that delivers one command byte plus a 16-bit data word per write
package asd_pkg;

    // command bytes of the three write registers
    localparam logic [7:0] CMD_ADC_SCAN = 8'h62;
    localparam logic [7:0] CMD_POWER_DOWN = 8'h64;
    localparam logic [7:0] CMD_DAC_LOAD = 8'h66;

    // field positions
    localparam int SCAN_CONT_BIT = 11;
    localparam int PWR_GLOBAL_BIT = 11;
    localparam int PWR_FORCE_REF_BIT = 10;
    localparam int PWR_WDOG_OFF_BIT = 9;
    localparam int PWR_OSC_OFF_BIT = 8;
    localparam int PWR_DAC_B_BIT = 4;
    localparam int PWR_DAC_A_BIT = 0;
    localparam int LOAD_A_BIT = 0;
    localparam int LOAD_B_BIT = 1;
    localparam int NUM_CHAN = 11;

    // reset values
    localparam logic [11:0] SCAN_RESET = 12'h000;
    localparam logic [11:0] POWER_RESET = 12'h8ff;
    localparam logic [11:0] DAC_RESET = 12'h000;
    localparam logic [3:0] CHAN_NONE = 4'hb;

    // timing
    localparam int CLK_HZ = 25000000;
    localparam int REF_UP_TIME_US = 50;
    localparam int REF_UP_CYCLES = (REF_UP_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int WDOG_TIME_MS = 80;
    localparam int WDOG_CYCLES_DEF = WDOG_TIME_MS * (CLK_HZ / 1000);

    // decoded serial write
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] data;
    } asd_cmd_t;

    // one fifo entry
    typedef struct packed {
        logic [3:0] chan;
        logic [11:0] value;
    } asd_result_t;

    typedef enum logic [1:0] {S_IDLE, S_REF_WAIT, S_START, S_WAIT} asd_state_t;

endpackage : asd_pkg

// ### src/asd_ctrl.sv
// adc scan control, software dac load and power-down control registers
// assumes CMD holds one decoded serial write for one cycle; adc core and fifo sit outside
//
// Functional notes
// - continuous flag repeats selected scan without commands
// - continuous only in clock modes 00, 01
// - fifo write only when monitor enable set
// - D0 internal, D1/D6 remote temperature select
// - D2/D7 select current-sense voltages
// - D3/D8 select dac codes
// - D4/D9 select gate-drive voltages
// - D5/D10 select auxiliary analog inputs
// - dac load at 66h, bits 15..2 ignored
// - load bit D1 copies channel b dac
// - load bit D0 copies channel a dac
// - global shutdown overrides, aborts scan to idle, disables dacs/adc
// - shutdown set at reset, scan and power-down writes still accepted, dac loads ignored
// - forced reference skips 50us power-up wait
// - watchdog restarts alu after 80ms unless off
// - oscillator-off bit clears on next command other than a power-down write, which loads it from D8
// - channel b power-down bits D7..D4, reset 1
// - channel a power-down bits D3..D0, reset 1
// - channels converted in ascending order 0..10
// - scan at 62h, power-down at 64h
// - continuous cleared: busy until scan ends, idle
`timescale 1ns/1ps
module asd_ctrl #(
    parameter int WDOG_CYCLES = asd_pkg::WDOG_CYCLES_DEF
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire asd_pkg::asd_cmd_t CMD,
    input wire logic [1:0] CLK_SEL,
    input wire logic ADC_MON_EN,
    input wire logic [11:0] DAC_IN_A,
    input wire logic [11:0] DAC_IN_B,
    input wire logic ADC_DONE,
    input wire logic [11:0] ADC_RESULT,
    input wire logic ALU_KICK,
    output logic [11:0] DAC_OUT_A,
    output logic [11:0] DAC_OUT_B,
    output logic ADC_START,
    output logic [3:0] ADC_CHAN,
    output logic [1:0] ADC_MODE,
    output logic FIFO_WR,
    output asd_pkg::asd_result_t FIFO_DATA,
    output logic BUSY,
    output logic [7:0] PWRDN,
    output logic DAC_EN_A,
    output logic DAC_EN_B,
    output logic ADC_EN,
    output logic REF_ON,
    output logic WDOG_EN,
    output logic OSC_OFF,
    output logic ALU_RESTART
);
    import asd_pkg::*;

    localparam int WDOG_W = $clog2(WDOG_CYCLES + 1);
    localparam int REF_W = $clog2(REF_UP_CYCLES + 1);

    // lowest selected channel at or above a start point
    function automatic logic [3:0] next_chan(input logic [10:0] mask, input logic [3:0] from);
        logic [3:0] res;
        res = CHAN_NONE;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (mask[i] && (4'(i) >= from)) begin
                res = 4'(i);
            end
        end
        return res;
    endfunction : next_chan

    ////////////////////////////////////////////////////////////////////////////
    // register file
    logic [11:0] scan_r, scan_nxt;
    logic [11:0] pwr_r, pwr_nxt;
    logic [11:0] dac_a_r, dac_a_nxt;
    logic [11:0] dac_b_r, dac_b_nxt;
    logic [7:0] pwrdn_r, pwrdn_nxt;
    logic dac_en_a_r, dac_en_a_nxt, dac_en_b_r, dac_en_b_nxt;
    logic adc_en_r, adc_en_nxt, wdog_en_r, wdog_en_nxt, osc_off_r, osc_off_nxt;
    logic global_shutdown, cont_eff;

    assign global_shutdown = pwr_r[PWR_GLOBAL_BIT];
    assign cont_eff = scan_r[SCAN_CONT_BIT] && !CLK_SEL[1];

    // command decode and derived power controls
    always_comb begin
        scan_nxt = scan_r;
        pwr_nxt = pwr_r;
        dac_a_nxt = dac_a_r;
        dac_b_nxt = dac_b_r;
        if (CMD.valid) begin
            pwr_nxt[PWR_OSC_OFF_BIT] = 1'b0;
            case (CMD.code)
                CMD_ADC_SCAN: scan_nxt = CMD.data[11:0];
                CMD_POWER_DOWN: pwr_nxt = CMD.data[11:0];
                CMD_DAC_LOAD: begin
                    // upper data bits are don't care
                    if (!global_shutdown && CMD.data[LOAD_A_BIT]) begin
                        dac_a_nxt = DAC_IN_A;
                    end
                    if (!global_shutdown && CMD.data[LOAD_B_BIT]) begin
                        dac_b_nxt = DAC_IN_B;
                    end
                end
                default: ;
            endcase
        end
        pwrdn_nxt = global_shutdown ? 8'hff : pwr_r[7:0];
        dac_en_a_nxt = !global_shutdown && !pwr_r[PWR_DAC_A_BIT];
        dac_en_b_nxt = !global_shutdown && !pwr_r[PWR_DAC_B_BIT];
        adc_en_nxt = !global_shutdown;
        wdog_en_nxt = !global_shutdown && !pwr_r[PWR_WDOG_OFF_BIT];
        osc_off_nxt = pwr_r[PWR_OSC_OFF_BIT];
    end

    // register file flops
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            scan_r <= SCAN_RESET;
            pwr_r <= POWER_RESET;
            dac_a_r <= DAC_RESET;
            dac_b_r <= DAC_RESET;
            pwrdn_r <= POWER_RESET[7:0];
            dac_en_a_r <= 1'b0;
            dac_en_b_r <= 1'b0;
            adc_en_r <= 1'b0;
            wdog_en_r <= 1'b0;
            osc_off_r <= 1'b0;
        end else begin
            scan_r <= scan_nxt;
            pwr_r <= pwr_nxt;
            dac_a_r <= dac_a_nxt;
            dac_b_r <= dac_b_nxt;
            pwrdn_r <= pwrdn_nxt;
            dac_en_a_r <= dac_en_a_nxt;
            dac_en_b_r <= dac_en_b_nxt;
            adc_en_r <= adc_en_nxt;
            wdog_en_r <= wdog_en_nxt;
            osc_off_r <= osc_off_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scan engine
    asd_state_t st_r, st_nxt;
    logic [3:0] ch_r, ch_nxt;
    logic [10:0] mask_r, mask_nxt;
    logic [REF_W-1:0] wait_r, wait_nxt;
    logic start_r, start_nxt, fifo_wr_r, fifo_wr_nxt, busy_r, busy_nxt, ref_r, ref_nxt;
    asd_result_t fifo_data_r, fifo_data_nxt;
    logic [3:0] first_ch, after_ch;

    assign first_ch = next_chan(CMD.data[10:0], 4'h0);
    assign after_ch = next_chan(mask_r, 4'(ch_r + 4'h1));

    // channel walk, continuous restart and fifo write
    always_comb begin
        st_nxt = st_r;
        ch_nxt = ch_r;
        mask_nxt = mask_r;
        wait_nxt = wait_r;
        start_nxt = 1'b0;
        fifo_wr_nxt = 1'b0;
        fifo_data_nxt = fifo_data_r;
        if (global_shutdown) begin
            st_nxt = S_IDLE;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (CMD.valid && CMD.code == CMD_ADC_SCAN && first_ch != CHAN_NONE) begin
                        mask_nxt = CMD.data[10:0];
                        ch_nxt = first_ch;
                        if (ref_r || pwr_r[PWR_FORCE_REF_BIT]) begin
                            st_nxt = S_START;
                        end else begin
                            st_nxt = S_REF_WAIT;
                            wait_nxt = REF_W'(REF_UP_CYCLES - 1);
                        end
                    end
                end
                S_REF_WAIT: begin
                    if (wait_r == '0) begin
                        st_nxt = S_START;
                    end else begin
                        wait_nxt = wait_r - 1'b1;
                    end
                end
                S_START: begin
                    start_nxt = 1'b1;
                    st_nxt = S_WAIT;
                end
                S_WAIT: begin
                    if (ADC_DONE) begin
                        fifo_wr_nxt = ADC_MON_EN;
                        fifo_data_nxt = '{chan: ch_r, value: ADC_RESULT};
                        if (after_ch != CHAN_NONE) begin
                            ch_nxt = after_ch;
                            st_nxt = S_START;
                        end else if (cont_eff && next_chan(scan_r[10:0], 4'h0) != CHAN_NONE) begin
                            mask_nxt = scan_r[10:0];
                            ch_nxt = next_chan(scan_r[10:0], 4'h0);
                            st_nxt = S_START;
                        end else begin
                            st_nxt = S_IDLE;
                        end
                    end
                end
                default: st_nxt = S_IDLE;
            endcase
        end
        busy_nxt = (st_nxt != S_IDLE) && !cont_eff;
        ref_nxt = !global_shutdown && (pwr_r[PWR_FORCE_REF_BIT] || st_nxt != S_IDLE);
    end

    // scan engine flops
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_r <= S_IDLE;
            ch_r <= 4'h0;
            mask_r <= 11'h000;
            wait_r <= '0;
            start_r <= 1'b0;
            fifo_wr_r <= 1'b0;
            fifo_data_r <= '0;
            busy_r <= 1'b0;
            ref_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ch_r <= ch_nxt;
            mask_r <= mask_nxt;
            wait_r <= wait_nxt;
            start_r <= start_nxt;
            fifo_wr_r <= fifo_wr_nxt;
            fifo_data_r <= fifo_data_nxt;
            busy_r <= busy_nxt;
            ref_r <= ref_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alu watchdog
    logic [WDOG_W-1:0] wd_cnt_r, wd_cnt_nxt;
    logic wd_fire_r, wd_fire_nxt;

    // count idle cycles of the alu, restart it on expiry
    always_comb begin
        wd_cnt_nxt = wd_cnt_r + 1'b1;
        wd_fire_nxt = 1'b0;
        if (!wdog_en_nxt || ALU_KICK) begin
            wd_cnt_nxt = '0;
        end else if (wd_cnt_r == WDOG_W'(WDOG_CYCLES - 1)) begin
            wd_cnt_nxt = '0;
            wd_fire_nxt = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wd_cnt_r <= '0;
            wd_fire_r <= 1'b0;
        end else begin
            wd_cnt_r <= wd_cnt_nxt;
            wd_fire_r <= wd_fire_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign DAC_OUT_A = dac_a_r;
    assign DAC_OUT_B = dac_b_r;
    assign ADC_START = start_r;
    assign ADC_CHAN = ch_r;
    assign FIFO_WR = fifo_wr_r;
    assign FIFO_DATA = fifo_data_r;
    assign BUSY = busy_r;
    assign PWRDN = pwrdn_r;
    assign DAC_EN_A = dac_en_a_r;
    assign DAC_EN_B = dac_en_b_r;
    assign ADC_EN = adc_en_r;
    assign REF_ON = ref_r;
    assign WDOG_EN = wdog_en_r;
    assign OSC_OFF = osc_off_r;
    assign ALU_RESTART = wd_fire_r;

    // conversion mode follows clock select
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ADC_MODE <= 2'h0;
        end else begin
            ADC_MODE <= CLK_SEL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    logic [3:0] prev_ch_r;
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            prev_ch_r <= 4'h0;
        end else if (ADC_START) begin
            prev_ch_r <= ADC_CHAN;
        end
    end

    property p_load_a;
        CMD.valid && CMD.code == CMD_DAC_LOAD && CMD.data[0] && !global_shutdown |=> DAC_OUT_A == $past(DAC_IN_A);
    endproperty
    a_load_a: assert property (p_load_a) else $error("dac a not loaded");
    property p_load_b;
        CMD.valid && CMD.code == CMD_DAC_LOAD && CMD.data[1] && !global_shutdown |=> DAC_OUT_B == $past(DAC_IN_B);
    endproperty
    a_load_b: assert property (p_load_b) else $error("dac b not loaded");
    property p_shutdown;
        global_shutdown ##1 global_shutdown |-> PWRDN == 8'hff && !DAC_EN_A && !DAC_EN_B && !ADC_EN && st_r == S_IDLE;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not enforced");
    property p_accept_in_shutdown;
        global_shutdown && CMD.valid && CMD.code == CMD_ADC_SCAN |=> scan_r == $past(CMD.data[11:0]);
    endproperty
    a_accept_in_shutdown: assert property (p_accept_in_shutdown) else $error("write lost in shutdown");
    property p_osc_clear;
        pwr_r[PWR_OSC_OFF_BIT] && CMD.valid && CMD.code != CMD_POWER_DOWN |=> ##1 !OSC_OFF;
    endproperty
    a_osc_clear: assert property (p_osc_clear) else $error("oscillator bit not cleared");
    property p_fifo_gate;
        FIFO_WR |-> $past(ADC_MON_EN) && $past(ADC_DONE);
    endproperty
    a_fifo_gate: assert property (p_fifo_gate) else $error("fifo written while monitor off");
    property p_order;
        ADC_START && ADC_CHAN != next_chan(mask_r, 4'h0) |-> ADC_CHAN > prev_ch_r && mask_r[ADC_CHAN];
    endproperty
    a_order: assert property (p_order) else $error("channel out of order");
    property p_continuous;
        st_r == S_WAIT && ADC_DONE && after_ch == CHAN_NONE && cont_eff && scan_r[10:0] != 11'h000 && !global_shutdown
            |=> ##1 ADC_START;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous scan stopped");
    property p_mode_stop;
        st_r == S_WAIT && ADC_DONE && after_ch == CHAN_NONE && CLK_SEL[1] |=> st_r == S_IDLE && !BUSY;
    endproperty
    a_mode_stop: assert property (p_mode_stop) else $error("continuous in wrong clock mode");
    // a scan that stays active past this edge keeps busy up, the last done lets it fall
    property p_busy;
        st_r != S_IDLE && !(st_r == S_WAIT && ADC_DONE && after_ch == CHAN_NONE) && !cont_eff && !global_shutdown
            |=> BUSY;
    endproperty
    a_busy: assert property (p_busy) else $error("busy low during final scan");
    property p_force_ref;
        pwr_r[PWR_FORCE_REF_BIT] && !global_shutdown |=> REF_ON;
    endproperty
    a_force_ref: assert property (p_force_ref) else $error("forced reference off");
    property p_wdog_off;
        !WDOG_EN |=> !ALU_RESTART;
    endproperty
    a_wdog_off: assert property (p_wdog_off) else $error("restart with watchdog off");

    logic a_continuous_hit;
    assign a_continuous_hit = st_r == S_WAIT && ADC_DONE && after_ch == CHAN_NONE && cont_eff;
    c_scan: cover property (ADC_START ##[1:50] FIFO_WR);
    c_continuous: cover property (a_continuous_hit);
    c_load: cover property (CMD.valid && CMD.code == CMD_DAC_LOAD && !global_shutdown);
    c_busy_end: cover property (BUSY ##1 !BUSY);

endmodule : asd_ctrl

// ### testbench/asd_adc_model.sv
// adc core stand-in: answers each start pulse with a done pulse and a result
// assumes start is a one-cycle pulse with the channel valid beside it
`timescale 1ns/1ps
module asd_adc_model (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic ADC_START,
    input wire logic [3:0] ADC_CHAN,
    output logic ADC_DONE,
    output logic [11:0] ADC_RESULT
);
    logic [1:0] cnt_r;
    logic [3:0] chan_r;
    ////////////////////////////////////////////////////////////////
    // latency counter, done three cycles after start
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cnt_r <= 2'h0;
            chan_r <= 4'h0;
        end else if (ADC_START) begin
            cnt_r <= 2'h3;
            chan_r <= ADC_CHAN;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end
    end
    // result only valid with done; inverted otherwise so stale values never match
    assign ADC_DONE = (cnt_r == 2'h1);
    assign ADC_RESULT = ADC_DONE ? {8'h5a, chan_r} : ~{8'h5a, chan_r};
endmodule : asd_adc_model

// ### testbench/asd_ctrl_test.sv
// self-checking bench for the scan, dac load and power-down control block
// assumes asd_adc_model answers conversions; bench acts as the serial host
`timescale 1ns/1ps
module asd_ctrl_test;
    import asd_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    asd_cmd_t cmd = '0;
    logic [1:0] clk_sel = 2'b00;
    logic mon_en = 1'b1;
    logic kick = 1'b0;
    logic [11:0] din_a = 12'h123;
    logic [11:0] din_b = 12'h456;
    logic [11:0] dout_a, dout_b, adc_result;
    logic adc_start, adc_done, fifo_wr, busy, den_a, den_b, adc_en, ref_on, wdog_en, osc_off, restart;
    logic [3:0] adc_chan;
    logic [1:0] adc_mode;
    logic [7:0] pwrdn;
    asd_result_t fifo_data;
    int err_count = 0;
    int tests_run = 0;
    int k;
    ////////////////////////////////////////////////////////////////
    // clock and instances
    always #20 core_clk = ~core_clk;
    asd_ctrl #(.WDOG_CYCLES(50)) u_dut (.CORE_CLK(core_clk), .RST(rst), .CMD(cmd), .CLK_SEL(clk_sel),
        .ADC_MON_EN(mon_en), .DAC_IN_A(din_a), .DAC_IN_B(din_b), .ADC_DONE(adc_done),
        .ADC_RESULT(adc_result), .ALU_KICK(kick), .DAC_OUT_A(dout_a), .DAC_OUT_B(dout_b),
        .ADC_START(adc_start), .ADC_CHAN(adc_chan), .ADC_MODE(adc_mode), .FIFO_WR(fifo_wr),
        .FIFO_DATA(fifo_data), .BUSY(busy), .PWRDN(pwrdn), .DAC_EN_A(den_a), .DAC_EN_B(den_b),
        .ADC_EN(adc_en), .REF_ON(ref_on), .WDOG_EN(wdog_en), .OSC_OFF(osc_off), .ALU_RESTART(restart));
    asd_adc_model u_adc (.CORE_CLK(core_clk), .RST(rst), .ADC_START(adc_start), .ADC_CHAN(adc_chan),
        .ADC_DONE(adc_done), .ADC_RESULT(adc_result));
    ////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    // one decoded write, valid high for one cycle
    task automatic wr(logic [7:0] code, logic [15:0] data);
        @(posedge core_clk);
        cmd <= '{1'b1, code, data};
        @(posedge core_clk);
        cmd <= '0;
    endtask : wr
    // counts start pulses over n cycles, none expected
    task automatic quiet(int n);
        int s;
        s = 0;
        repeat (n) begin
            tick(1);
            s += (adc_start === 1'b1);
        end
        chk("idle starts", 16'h0, s[15:0]);
    endtask : quiet
    function automatic int nxt(logic [10:0] m, int l);
        for (int i = l + 1; i < 11; i++) begin
            if (m[i]) return i;
        end
        for (int i = 0; i < 11; i++) begin
            if (m[i]) return i;
        end
        return 0;
    endfunction : nxt
    // scan write, then follow channel order and fifo entries
    task automatic scan(logic [15:0] d, int nst, int nfifo);
        int st, ff, l, j;
        st = 0;
        ff = 0;
        l = -1;
        wr(CMD_ADC_SCAN, d);
        for (j = 0; j < 400 && !(st >= nst && ff >= nfifo && busy === 1'b0); j++) begin
            tick(1);
            if (adc_start === 1'b1) begin
                l = nxt(d[10:0], l);
                st++;
                chk("adc chan", l[15:0], {12'h0, adc_chan});
                chk("adc mode", {14'h0, clk_sel}, {14'h0, adc_mode});
            end
            if (d[11] && !clk_sel[1] && st > 0) chk("busy in continuous", 16'h0, {15'h0, busy});
            if (fifo_wr === 1'b1) begin
                ff++;
                chk("fifo data", {l[3:0], 8'h5a, l[3:0]}, fifo_data);
            end
        end
        chk("fifo count", nfifo[15:0], ff[15:0]);
        if (j >= 400) begin
            err_count++;
            $display("BAD scan timeout expected %0d seen %0d", nst, st);
            complete_run();
        end
    endtask : scan
    // continuous run, clear mid-scan, busy to the end of the scan
    task automatic cont(logic [1:0] mode);
        clk_sel <= mode;
        scan(16'h0803, 6, 6);
        for (k = 0; k < 50 && !(adc_start === 1'b1 && adc_chan === 4'h0); k++) tick(1);
        wr(CMD_ADC_SCAN, 16'h0003);
        tick(1);
        chk("busy after clear", 16'h1, {15'h0, busy});
        for (k = 0; k < 50 && busy !== 1'b0; k++) tick(1);
        quiet(20);
        $display("test continuous mode %0d done", mode);
    endtask : cont
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk("pwrdn reset", 16'h00ff, {8'h0, pwrdn});
        chk("enables reset", 16'h0, {12'h0, den_a, den_b, adc_en, busy});
        wr(CMD_DAC_LOAD, 16'h0003);
        tick(2);
        chk("load in shutdown", 16'h0, {4'h0, dout_a} | {4'h0, dout_b});
        wr(CMD_ADC_SCAN, 16'h0001);
        quiet(30);
        $display("test reset done");
    endtask : t_reset
    task automatic t_power();
        wr(CMD_POWER_DOWN, 16'h0000);
        tick(1);
        chk("pwrdn clear", 16'h0, {8'h0, pwrdn});
        chk("enables on", 16'h000f, {12'h0, den_a, den_b, adc_en, wdog_en});
        for (int i = 0; i < 8; i++) begin
            wr(CMD_POWER_DOWN, 16'h0001 << i);
            tick(1);
            chk("pwrdn bit", 16'h0001 << i, {8'h0, pwrdn});
        end
        wr(CMD_POWER_DOWN, 16'h0100);
        tick(1);
        chk("osc off set", 16'h1, {15'h0, osc_off});
        wr(8'h70, 16'h0000);
        tick(1);
        chk("osc off cleared", 16'h0, {15'h0, osc_off});
        $display("test power done");
    endtask : t_power
    task automatic t_load();
        wr(CMD_DAC_LOAD, 16'hfffc);
        tick(1);
        chk("load high bits", 16'h0, {4'h0, dout_a} | {4'h0, dout_b});
        wr(CMD_DAC_LOAD, 16'h0001);
        tick(1);
        chk("load a", {din_a, 4'h0}, {dout_a, dout_b[3:0]});
        wr(CMD_DAC_LOAD, 16'h0002);
        tick(1);
        chk("load b", {4'h0, din_b}, {4'h0, dout_b});
        $display("test load done");
    endtask : t_load
    task automatic t_ref();
        wr(CMD_POWER_DOWN, 16'h0000);
        wr(CMD_ADC_SCAN, 16'h0001);
        for (k = 0; k < 1400 && adc_start !== 1'b1; k++) tick(1);
        chk("cold ref wait", 16'h1, {15'h0, k >= REF_UP_CYCLES - 2 && k < 1400});
        tick(10);
        wr(CMD_POWER_DOWN, 16'h0400);
        tick(1);
        chk("ref forced", 16'h1, {15'h0, ref_on});
        $display("test reference done");
    endtask : t_ref
    task automatic t_scans();
        scan(16'h0005, 2, 2);
        for (int i = 0; i < 11; i++) scan(16'h0001 << i, 1, 1);
        scan(16'h07ff, 11, 11);
        quiet(10);
        mon_en <= 1'b0;
        scan(16'h0006, 2, 0);
        mon_en <= 1'b1;
        clk_sel <= 2'b10;
        scan(16'h0803, 2, 2);
        quiet(20);
        $display("test scans done");
    endtask : t_scans
    task automatic t_wdog();
        int r;
        r = 0;
        for (int i = 0; i < 150; i++) begin
            kick <= (i % 20 == 0);
            tick(1);
            r += (restart === 1'b1);
        end
        kick <= 1'b0;
        chk("kicked restarts", 16'h0, r[15:0]);
        tick(60);
        for (k = 0; k < 60 && restart !== 1'b1; k++) tick(1);
        chk("watchdog expiry", 16'h1, {15'h0, k < 60});
        wr(CMD_POWER_DOWN, 16'h0600);
        tick(1);
        chk("watchdog off", 16'h0, {15'h0, wdog_en});
        r = 0;
        repeat (120) begin
            tick(1);
            r += (restart === 1'b1);
        end
        chk("restarts when off", 16'h0, r[15:0]);
        $display("test watchdog done");
    endtask : t_wdog
    task automatic t_abort();
        wr(CMD_POWER_DOWN, 16'h0400);
        wr(CMD_ADC_SCAN, 16'h07ff);
        tick(4);
        wr(CMD_POWER_DOWN, 16'h0800);
        tick(2);
        chk("shutdown outputs", 16'hff00, {pwrdn, 5'h0, adc_en, busy, den_a});
        quiet(30);
        $display("test abort done");
    endtask : t_abort
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        tick(10);
        rst <= 1'b0;
        tick(1);
        t_reset();
        t_power();
        t_load();
        t_ref();
        t_scans();
        cont(2'b00);
        cont(2'b01);
        t_wdog();
        t_abort();
        complete_run();
    end
endmodule : asd_ctrl_test
